// ===== logic/cstrc_pkg.sv
/*
 * Constants and carrier types for the clock, stop and reset controller.
 * Assumes an 8-bit register file reached by byte address in one register set.
 */
package cstrc_pkg;

	// ----------------------------------------
	// Register addresses
	// ----------------------------------------
	localparam logic [7:0] ADDR_BASIC_TIMER_CONTROL  = 8'hd3;
	localparam logic [7:0] ADDR_CPU_CLOCK_DIVIDER    = 8'hd4;
	localparam logic [7:0] ADDR_STOP_INSTRUCTION_GATE = 8'hed;
	localparam logic [7:0] ADDR_OSCILLATOR_CONTROL   = 8'hfa;
	localparam logic [7:0] ADDR_BASIC_TIMER_COUNT    = 8'hfd;

	// ----------------------------------------
	// Reset values and keys
	// ----------------------------------------
	localparam logic [7:0] RST_STOP_GATE   = 8'h00;
	localparam logic [7:0] RST_BTIMER_CTRL = 8'h00;
	localparam logic [1:0] RST_CPU_DIV     = 2'h0;
	localparam logic [7:0] STOP_KEY        = 8'ha5;
	localparam logic [3:0] WDT_OFF_KEY     = 4'ha;
	localparam logic [15:0] RESET_VECTOR   = 16'h0100;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int DIV_LSB       = 3;
	localparam int DIV_MSB       = 4;
	localparam int OSC_SEL_BIT   = 0;
	localparam int SUB_STOP_BIT  = 2;
	localparam int MAIN_STOP_BIT = 3;
	localparam int BT_CLR_BIT    = 0;
	localparam int BT_SEL_LSB    = 2;
	localparam int BT_SEL_MSB    = 3;
	localparam int WDT_KEY_LSB   = 4;
	localparam int WDT_KEY_MSB   = 7;

	// ----------------------------------------
	// Divider encodings and timer prescale
	// ----------------------------------------
	localparam logic [1:0] DIV_BY_16 = 2'h0;
	localparam logic [1:0] DIV_BY_8  = 2'h1;
	localparam logic [1:0] DIV_BY_2  = 2'h2;
	localparam logic [1:0] DIV_BY_1  = 2'h3;
	localparam int BT_PRESCALE_W = 12;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic [7:0] data;
	} cstrc_regwr_t;

	typedef enum logic [1:0] {
		ST_RESET = 2'h0,
		ST_STAB  = 2'h1,
		ST_RUN   = 2'h3,
		ST_STOP  = 2'h2
	} cstrc_state_t;

endpackage

// ===== logic/cstrc_clock_stop_reset_control.sv
/*
 * Clock select, CPU clock divider, stop gate, basic-timer watchdog and reset sequencer.
 * Assumes the CPU writes registers with a one-cycle strobe and decodes the stop opcode itself;
 * the reset pin arrives already through a Schmitt buffer and is asynchronous to clk_i.
 */
// How it works
// - Stop gate clears to zero on reset
// - Stop allowed only with key a5
// - Select bit routes main or sub clock
// - Separate stop bits for each oscillator
// - Divide selected clock by 16,8,2,1
// - Reset pin synchronised before internal use
// - Reset disables all interrupts
// - Reset leaves watchdog enabled
// - Reset sets ports input
// - Reset restores all control registers
// - Program counter loads 0100h on reset
// - No fetch until stabilisation time elapses
// - Watchdog overflow forces full system reset
// - Upper nibble 1010b disables watchdog
// - Divider defaults to divide-by-16
// - Main oscillator selected after reset
`timescale 1ns/100ps
module cstrc_clock_stop_reset_control #(
	parameter int BT_W = 8
) (
	// Clock and reset
	input  wire logic                   clk_i,
	input  wire logic                   nrst_i,
	// Pins and events
	input  wire logic                   reset_pin_n_i,
	input  wire logic                   wake_i,
	input  wire logic                   stop_insn_i,
	// Register port
	input  wire cstrc_pkg::cstrc_regwr_t reg_wr_i,
	input  wire logic [7:0]             reg_rd_addr_i,
	output logic [7:0]                  reg_rd_data_o,
	// Clock controls
	output logic                        sel_sub_o,
	output logic                        main_osc_stop_o,
	output logic                        sub_osc_stop_o,
	output logic                        cpu_clk_en_o,
	// Reset and sequencing
	output logic                        sys_rst_o,
	output logic                        int_disable_o,
	output logic                        ports_input_o,
	output logic                        pc_load_o,
	output logic [15:0]                 pc_vector_o,
	output logic                        fetch_en_o,
	output logic                        stop_mode_o,
	output logic                        stop_ignored_o
);

	// ----------------------------------------
	// Reset pin synchroniser
	// ----------------------------------------
	logic pin_q1;
	logic pin_q2;
	logic wake_q1;
	logic wake_q2;
	logic wdt_fire;
	logic int_rst;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pin_q1  <= 1'b0;
			pin_q2  <= 1'b0;
			wake_q1 <= 1'b0;
			wake_q2 <= 1'b0;
		end else begin
			pin_q1  <= reset_pin_n_i;
			pin_q2  <= pin_q1;
			// Wake comes from a pin too, so it gets the same two stages
			wake_q1 <= wake_i;
			wake_q2 <= wake_q1;
		end
	end

	// Watchdog fire counts as a pin reset so one path restores everything
	assign int_rst = !pin_q2 || wdt_fire;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] stop_instruction_gate;
	logic [1:0] cpu_div;
	logic       osc_sel;
	logic       main_stop;
	logic       sub_stop;
	logic [7:0] basic_timer_control;
	logic       bt_clr;
	logic       wr_at;

	always_comb begin
		wr_at = reg_wr_i.wr && !int_rst;
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			stop_instruction_gate <= cstrc_pkg::RST_STOP_GATE;
		end else if (int_rst) begin
			stop_instruction_gate <= cstrc_pkg::RST_STOP_GATE;
		end else if (wr_at && reg_wr_i.addr == cstrc_pkg::ADDR_STOP_INSTRUCTION_GATE) begin
			stop_instruction_gate <= reg_wr_i.data;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cpu_div <= cstrc_pkg::RST_CPU_DIV;
		end else if (int_rst) begin
			cpu_div <= cstrc_pkg::RST_CPU_DIV;
		end else if (wr_at && reg_wr_i.addr == cstrc_pkg::ADDR_CPU_CLOCK_DIVIDER) begin
			cpu_div <= reg_wr_i.data[cstrc_pkg::DIV_MSB:cstrc_pkg::DIV_LSB];
		end
	end

	// Sequencing of select and stop bits is left to software; no interlock here
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			osc_sel   <= 1'b0;
			main_stop <= 1'b0;
			sub_stop  <= 1'b0;
		end else if (int_rst) begin
			osc_sel   <= 1'b0;
			main_stop <= 1'b0;
			sub_stop  <= 1'b0;
		end else if (wr_at && reg_wr_i.addr == cstrc_pkg::ADDR_OSCILLATOR_CONTROL) begin
			osc_sel   <= reg_wr_i.data[cstrc_pkg::OSC_SEL_BIT];
			main_stop <= reg_wr_i.data[cstrc_pkg::MAIN_STOP_BIT];
			sub_stop  <= reg_wr_i.data[cstrc_pkg::SUB_STOP_BIT];
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			basic_timer_control <= cstrc_pkg::RST_BTIMER_CTRL;
			bt_clr              <= 1'b0;
		end else if (int_rst) begin
			basic_timer_control <= cstrc_pkg::RST_BTIMER_CTRL;
			bt_clr              <= 1'b0;
		end else begin
			bt_clr <= 1'b0;
			if (wr_at && reg_wr_i.addr == cstrc_pkg::ADDR_BASIC_TIMER_CONTROL) begin
				basic_timer_control <= reg_wr_i.data;
				bt_clr              <= reg_wr_i.data[cstrc_pkg::BT_CLR_BIT];
			end
		end
	end

	// ----------------------------------------
	// Basic timer and watchdog
	// ----------------------------------------
	logic [cstrc_pkg::BT_PRESCALE_W-1:0] bt_pre;
	logic [BT_W-1:0]                     bt_cnt;
	logic                                bt_tick;
	logic                                bt_ovf;
	logic                                wdt_on;

	always_comb begin
		case (basic_timer_control[cstrc_pkg::BT_SEL_MSB:cstrc_pkg::BT_SEL_LSB])
			2'h0:    bt_tick = &bt_pre;
			2'h1:    bt_tick = &bt_pre[9:0];
			2'h2:    bt_tick = &bt_pre[6:0];
			default: bt_tick = &bt_pre[3:0];
		endcase
		bt_ovf = bt_tick && &bt_cnt;
		wdt_on = basic_timer_control[cstrc_pkg::WDT_KEY_MSB:cstrc_pkg::WDT_KEY_LSB] != cstrc_pkg::WDT_OFF_KEY;
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			bt_pre <= '0;
			bt_cnt <= '0;
		end else if (int_rst || bt_clr || stop_mode_o) begin
			// Held clear while stopped, so wake-up always waits a full interval
			bt_pre <= '0;
			bt_cnt <= '0;
		end else begin
			bt_pre <= bt_pre + 1'b1;
			if (bt_tick) begin
				bt_cnt <= bt_cnt + 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Reset and stop sequencer
	// ----------------------------------------
	cstrc_pkg::cstrc_state_t state;
	cstrc_pkg::cstrc_state_t next_state;
	logic                    stop_ok;

	always_comb begin
		stop_ok = stop_instruction_gate == cstrc_pkg::STOP_KEY;
		// Watchdog only guards running code; stabilisation uses the same overflow
		wdt_fire = (state == cstrc_pkg::ST_RUN) && bt_ovf && wdt_on;
		case (state)
			cstrc_pkg::ST_RESET: next_state = cstrc_pkg::ST_STAB;
			cstrc_pkg::ST_STAB:  next_state = bt_ovf ? cstrc_pkg::ST_RUN : cstrc_pkg::ST_STAB;
			cstrc_pkg::ST_RUN:   next_state = (stop_insn_i && stop_ok) ? cstrc_pkg::ST_STOP : cstrc_pkg::ST_RUN;
			cstrc_pkg::ST_STOP:  next_state = wake_q2 ? cstrc_pkg::ST_STAB : cstrc_pkg::ST_STOP;
			default:             next_state = cstrc_pkg::ST_RESET;
		endcase
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state <= cstrc_pkg::ST_RESET;
		end else if (int_rst) begin
			state <= cstrc_pkg::ST_RESET;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			stop_ignored_o <= 1'b0;
		end else begin
			stop_ignored_o <= !int_rst && state == cstrc_pkg::ST_RUN && stop_insn_i && !stop_ok;
		end
	end

	// ----------------------------------------
	// CPU clock divider
	// ----------------------------------------
	logic [3:0] div_cnt;
	logic       div_hit;

	always_comb begin
		case (cpu_div)
			cstrc_pkg::DIV_BY_16: div_hit = &div_cnt;
			cstrc_pkg::DIV_BY_8:  div_hit = &div_cnt[2:0];
			cstrc_pkg::DIV_BY_2:  div_hit = div_cnt[0];
			default:              div_hit = 1'b1;
		endcase
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			div_cnt <= '0;
		end else begin
			div_cnt <= div_cnt + 1'b1;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// CPU clock is an enable so the divider never makes a runt clock edge
	assign cpu_clk_en_o    = div_hit && state == cstrc_pkg::ST_RUN;
	assign sel_sub_o       = osc_sel;
	assign main_osc_stop_o = main_stop || state == cstrc_pkg::ST_STOP;
	assign sub_osc_stop_o  = sub_stop;
	assign sys_rst_o       = int_rst || state == cstrc_pkg::ST_RESET;
	assign int_disable_o   = sys_rst_o;
	assign ports_input_o   = sys_rst_o;
	assign pc_load_o       = sys_rst_o;
	assign pc_vector_o     = cstrc_pkg::RESET_VECTOR;
	// Fetch drops in the very cycle a reset asserts, not one cycle later
	assign fetch_en_o      = state == cstrc_pkg::ST_RUN && !int_rst;
	assign stop_mode_o     = state == cstrc_pkg::ST_STOP;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			reg_rd_data_o <= 8'h00;
		end else begin
			case (reg_rd_addr_i)
				cstrc_pkg::ADDR_STOP_INSTRUCTION_GATE: reg_rd_data_o <= stop_instruction_gate;
				cstrc_pkg::ADDR_CPU_CLOCK_DIVIDER:     reg_rd_data_o <= {3'h0, cpu_div, 3'h0};
				cstrc_pkg::ADDR_OSCILLATOR_CONTROL:    reg_rd_data_o <= {4'h0, main_stop, sub_stop, 1'b0, osc_sel};
				cstrc_pkg::ADDR_BASIC_TIMER_CONTROL:   reg_rd_data_o <= basic_timer_control;
				cstrc_pkg::ADDR_BASIC_TIMER_COUNT:     reg_rd_data_o <= 8'(bt_cnt);
				default:                               reg_rd_data_o <= 8'h00;
			endcase
		end
	end

endmodule

// ===== verification/cstrc_monitor.sv
/* Checker for the clock, stop and reset controller.
   Assumes it is bound onto the controller top and sees its ports only. */
`timescale 1ns/100ps
module cstrc_monitor #(
	parameter int BT_W = 8
) (
	input wire logic                    clk_i,
	input wire logic                    nrst_i,
	input wire logic                    reset_pin_n_i,
	input wire logic                    stop_insn_i,
	input wire cstrc_pkg::cstrc_regwr_t reg_wr_i,
	input wire logic [7:0]              reg_rd_addr_i,
	input wire logic [7:0]              reg_rd_data_o,
	input wire logic                    sel_sub_o,
	input wire logic                    main_osc_stop_o,
	input wire logic                    sub_osc_stop_o,
	input wire logic                    cpu_clk_en_o,
	input wire logic                    sys_rst_o,
	input wire logic                    int_disable_o,
	input wire logic                    fetch_en_o,
	input wire logic                    stop_mode_o,
	input wire logic                    stop_ignored_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	// ----------------------------------------
	// Shadows, cleared by any reset
	// ----------------------------------------
	logic [7:0] gate;
	logic [1:0] div;
	wire logic  wok = reg_wr_i.wr && !sys_rst_o;
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i)
			gate <= 8'h00;
		else if (sys_rst_o)
			gate <= 8'h00;
		else if (wok && reg_wr_i.addr == 8'hed)
			gate <= reg_wr_i.data;
	end
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i)
			div <= 2'h0;
		else if (sys_rst_o)
			div <= 2'h0;
		else if (wok && reg_wr_i.addr == 8'hd4)
			div <= reg_wr_i.data[4:3];
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	AST_GATE_READ: assert property (!$past(sys_rst_o) && $past(reg_rd_addr_i) == 8'hed
		|-> reg_rd_data_o == $past(gate)) else $error("gate readback differs");
	AST_STOP_GO: assert property (stop_insn_i && fetch_en_o && !sys_rst_o && gate == 8'ha5
		|=> stop_mode_o && main_osc_stop_o && !fetch_en_o) else $error("keyed stop not taken");
	AST_STOP_IGN: assert property (stop_insn_i && fetch_en_o && !sys_rst_o && gate != 8'ha5
		|=> stop_ignored_o && !stop_mode_o) else $error("unkeyed stop not ignored");
	AST_SEL: assert property (wok && fetch_en_o && reg_wr_i.addr == 8'hfa
		|=> sel_sub_o == $past(reg_wr_i.data[0])) else $error("clock select wrong");
	AST_RST_CLR: assert property (sys_rst_o |=> !sel_sub_o && !sub_osc_stop_o)
		else $error("oscillator control not cleared");
	AST_DIV1: assert property (fetch_en_o && div == 2'h3 |-> cpu_clk_en_o)
		else $error("undivided enable missing");
	AST_DIV16: assert property (cpu_clk_en_o && div == 2'h0
		|=> (!cpu_clk_en_o || div != 2'h0)[*8]) else $error("divide by 16 too fast");
	AST_SYNC: assert property (!reset_pin_n_i [*3] |-> sys_rst_o)
		else $error("pin reset not seen");
	AST_RST_OUT: assert property (sys_rst_o |-> int_disable_o && !fetch_en_o)
		else $error("reset outputs wrong");
endmodule

// ===== verification/cstrc_pin_model.sv
/* Model of the reset pin and wake source outside the controller.
   Assumes the bench shortens the low interval; the pin is always driven. */
`timescale 1ns/100ps
module cstrc_pin_model #(
	parameter int LOW_CYC = 100000
) (
	input  wire logic clk_i,
	input  wire logic rst_req_i,
	input  wire logic wake_req_i,
	output logic      reset_pin_n_o,
	output logic      wake_o
);
	int cnt = 0;
	// Pin held low a full interval at power-up and on each request
	always_ff @(posedge clk_i) begin
		if (rst_req_i)
			cnt <= 0;
		else if (cnt < LOW_CYC)
			cnt <= cnt + 1;
	end
	assign reset_pin_n_o = (cnt >= LOW_CYC);
	always_ff @(posedge clk_i)
		wake_o <= wake_req_i;
endmodule

// ===== verification/cstrc_clock_stop_reset_control_tb_top.sv
/* Self-checking bench for the clock, stop and reset controller.
   Assumes the package, design, pin model and checker are compiled first. */
`timescale 1ns/100ps
module cstrc_clock_stop_reset_control_tb_top;
	localparam int BT_W = 2;
	logic clk_i = 1'b0, nrst_i = 1'b0, rq = 1'b0, wq = 1'b0, stop_insn_i = 1'b0;
	logic [7:0] ra = 8'h00, rd;
	logic [15:0] pcv;
	cstrc_pkg::cstrc_regwr_t ws = '0;
	logic pin, wk, sel, mst, sst, cen, srst, intd, pin_in, pcl, fen, stm, sti;
	int n_fail = 0, cmp_count = 0, cyc = 0;
	cstrc_pin_model #(.LOW_CYC(20)) pm (.clk_i(clk_i), .rst_req_i(rq), .wake_req_i(wq),
		.reset_pin_n_o(pin), .wake_o(wk));
	cstrc_clock_stop_reset_control #(.BT_W(BT_W)) uut (.clk_i(clk_i), .nrst_i(nrst_i),
		.reset_pin_n_i(pin), .wake_i(wk), .stop_insn_i(stop_insn_i), .reg_wr_i(ws),
		.reg_rd_addr_i(ra), .reg_rd_data_o(rd), .sel_sub_o(sel), .main_osc_stop_o(mst),
		.sub_osc_stop_o(sst), .cpu_clk_en_o(cen), .sys_rst_o(srst), .int_disable_o(intd),
		.ports_input_o(pin_in), .pc_load_o(pcl), .pc_vector_o(pcv), .fetch_en_o(fen),
		.stop_mode_o(stm), .stop_ignored_o(sti));
	initial forever #5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_fail++;
			summarize();
		end
	end
	task automatic summarize();
		if (n_fail == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		ws <= '{1'b1, a, d};
		@(posedge clk_i);
		ws.wr <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		ra <= a;
		repeat (2) @(posedge clk_i);
		chk("read", 16'(e), 16'(rd));
	endtask
	task automatic upto(ref logic s, input logic lv, input int lim);
		for (int i = 0; i < lim && s !== lv; i++)
			@(posedge clk_i);
		chk("flag", 16'(lv), 16'(s));
	endtask
	task automatic stp();
		stop_insn_i <= 1'b1;
		@(posedge clk_i);
		stop_insn_i <= 1'b0;
		@(posedge clk_i);
	endtask
	// Pulses seen in 32 cycles for each divider code
	function automatic int exp_pulses(input logic [1:0] d);
		return (d == 2'h3) ? 32 : (d == 2'h2) ? 16 : (d == 2'h1) ? 4 : 2;
	endfunction
	initial begin
		logic [7:0] v;
		int n;
		void'($urandom(32'ha7ad));
		repeat (4) @(posedge clk_i);
		nrst_i <= 1'b1;
		repeat (30) @(posedge clk_i);
		rdc(8'hed, 8'h00);
		rdc(8'hd4, 8'h00);
		rdc(8'hfa, 8'h00);
		rdc(8'hfe, 8'h00);
		rdc(8'hd3, 8'h00);
		// Watchdog off and fastest tick, so stabilisation is short
		wr(8'hd3, 8'hac);
		upto(fen, 1'b1, 20000);
		chk("vector", 16'h0100, pcv);
		for (int i = 0; i < 8; i++) begin
			v = 8'($urandom);
			if (v == 8'ha5)
				v = 8'h5a;
			wr(8'hed, v);
			stp();
			chk("ignored", 16'h1, 16'(sti));
			chk("stop", 16'h0, 16'(stm));
		end
		wr(8'hed, 8'ha5);
		stp();
		chk("stop", 16'h1, 16'(stm));
		chk("mainstop", 16'h1, 16'(mst));
		wq <= 1'b1;
		@(posedge clk_i);
		wq <= 1'b0;
		upto(fen, 1'b1, 2000);
		for (int d = 0; d < 4; d++) begin
			wr(8'hd4, 8'(d << 3));
			n = 0;
			repeat (32) @(posedge clk_i) n += int'(cen);
			chk("pulses", 16'(exp_pulses(2'(d))), 16'(n));
		end
		wr(8'hfa, 8'h01);
		chk("sel", 16'h1, 16'(sel));
		wr(8'hfa, 8'h09);
		chk("mainstop", 16'h1, 16'(mst));
		wr(8'hfa, 8'h01);
		repeat (16) @(posedge clk_i);
		wr(8'hfa, 8'h04);
		chk("oscsel", 16'h0002, 16'({mst, sst, sel}));
		wr(8'hd3, 8'h0c);
		upto(srst, 1'b1, 300);
		chk("intoff", 16'h7, 16'({intd, pin_in, pcl}));
		upto(srst, 1'b0, 40);
		wr(8'hd3, 8'hac);
		upto(fen, 1'b1, 2000);
		rdc(8'hd4, 8'h00);
		wr(8'hfa, 8'h04);
		wr(8'hed, 8'h33);
		rq <= 1'b1;
		@(posedge clk_i);
		rq <= 1'b0;
		upto(srst, 1'b1, 5);
		upto(srst, 1'b0, 60);
		wr(8'hd3, 8'hac);
		upto(fen, 1'b1, 2000);
		rdc(8'hfa, 8'h00);
		rdc(8'hed, 8'h00);
		summarize();
	end
endmodule
bind cstrc_clock_stop_reset_control cstrc_monitor #(.BT_W(BT_W)) mon (.clk_i(clk_i), .nrst_i(nrst_i),
	.reset_pin_n_i(reset_pin_n_i), .stop_insn_i(stop_insn_i), .reg_wr_i(reg_wr_i),
	.reg_rd_addr_i(reg_rd_addr_i), .reg_rd_data_o(reg_rd_data_o), .sel_sub_o(sel_sub_o),
	.main_osc_stop_o(main_osc_stop_o), .sub_osc_stop_o(sub_osc_stop_o), .cpu_clk_en_o(cpu_clk_en_o),
	.sys_rst_o(sys_rst_o), .int_disable_o(int_disable_o), .fetch_en_o(fetch_en_o),
	.stop_mode_o(stop_mode_o), .stop_ignored_o(stop_ignored_o));
